// ==== logic/wbim_regs.vh ====
/*
 constants for the wide two-bank interleaved memory controller:
 widths, line geometry and access timing.
 assumes it is included by bare name and nothing else defines these macros.
*/
`ifndef WBIM_REGS_VH
`define WBIM_REGS_VH

// line and check word geometry
`define WBIM_DATA_W 512
`define WBIM_CHECK_W 64
`define WBIM_MEM_W 576
`define WBIM_WORD_W 64
`define WBIM_WORD_CHK_W 8
`define WBIM_WORDS 8

// board organisation
`define WBIM_BANKS 2
`define WBIM_MODULES_PER_BANK 8

// physical address and interleave
`define WBIM_ADDR_W 41
`define WBIM_LINE_OFS 6
`define WBIM_LINE_W 35
`define WBIM_WAYS_LOG2_W 3
`define WBIM_MAX_WAYS_LOG2 3'h4
`define WBIM_SLOT_W 4

// row and column of the in-bank line address, sized for 1 Gbit devices
`define WBIM_ROW_W 14
`define WBIM_COL_W 14
`define WBIM_BANK_LINE_W 28

// timing in ns and derived cycle counts
`define WBIM_CLK_NS 100
`define WBIM_T_ACCESS_NS 100
`define WBIM_T_RECOVER_NS 100
`define WBIM_ACC_CYC ((`WBIM_T_ACCESS_NS + `WBIM_CLK_NS - 1) / `WBIM_CLK_NS)
`define WBIM_REC_CYC ((`WBIM_T_RECOVER_NS + `WBIM_CLK_NS - 1) / `WBIM_CLK_NS)
`define WBIM_SYNC_STAGES 2
`define WBIM_CNT_W 8

`endif

// ==== logic/wbim_ecc.v ====
/*
 single-error-correct, double-error-detect code over one 64-bit word
 with 8 check bits; encodes data_in and checks it against chk_in.
 assumes purely combinational use; the parent registers around it.
*/
`timescale 1ns/10ps
`include "wbim_regs.vh"

module wbim_ecc (
    input wire [`WBIM_WORD_W-1:0] data_in, // word to encode or check
    input wire [`WBIM_WORD_CHK_W-1:0] chk_in, // stored check bits
    output reg [`WBIM_WORD_CHK_W-1:0] chk_out, // check bits of data_in
    output reg [`WBIM_WORD_W-1:0] data_fix, // data_in with one bit corrected
    output reg err_single, // single bit error seen
    output reg err_double // uncorrectable error seen
);
    integer i;
    integer j;
    integer k;
    reg [6:0] ham;
    reg [6:0] syn;
    reg all_par;

    // hamming positions 1..71, data on non powers of two, plus overall parity
    always @* begin
        ham = 7'h00;
        j = 0;
        for (i = 1; i < 72; i = i + 1) begin
            if ((i & (i - 1)) != 0) begin
                for (k = 0; k < 7; k = k + 1) begin
                    if (((i >> k) & 1) == 1)
                        ham[k] = ham[k] ^ data_in[j];
                end
                j = j + 1;
            end
        end
        chk_out = {(^data_in) ^ (^ham), ham};
        syn = ham ^ chk_in[6:0];
        all_par = (^data_in) ^ (^chk_in);
        // correct the addressed data bit; a check bit hit needs no data fix
        data_fix = data_in;
        j = 0;
        for (i = 1; i < 72; i = i + 1) begin
            if ((i & (i - 1)) != 0) begin
                if (all_par && (syn == i[6:0]))
                    data_fix[j] = ~data_in[j]; // R5
                j = j + 1;
            end
        end
        err_single = all_par; // R5
        err_double = (!all_par) && (syn != 7'h00);
    end
endmodule

// ==== logic/wbim_ctrl.v ====
/*
 memory controller for one board: two banks of eight modules, each bank
 moving a whole 64-byte line plus check bits per access, with bank
 selection by a configurable interleave of up to sixteen ways.
 assumes requests come from logic on CLK, the interleave settings are
 quasi-static pins, and the module banks answer reads within the
 access time on MEM_RDATA.
*/
`timescale 1ns/10ps
`include "wbim_regs.vh"

// Notes on behaviour
// R1: each bank moves a full 64-byte line with check bits, 576 bits, per access.
// R2: exactly two banks per board, each eight modules used as one wide word.
// R3: row and column address fields are sized for devices up to one gigabit.
// R4: physical request addresses are 41 bits, two terabytes at most.
// R5: reads are checked, single-bit errors corrected, corrected data returned.
// R6: consecutive aligned 64-byte lines go to successive banks of a group.
// R7: interleave groups of up to sixteen banks, possibly across boards.
// R8: unequal banks: four-way low region, two-way for the rest of large banks.
// R9: bank chosen from address bits just above bit five; higher bits in-bank.
module wbim_ctrl #(
    parameter ACC_CYC = `WBIM_ACC_CYC,
    parameter REC_CYC = `WBIM_REC_CYC
) (
    input wire CLK, // system clock, 10 MHz
    input wire RST, // asynchronous reset, active high
    input wire REQ_VALID, // line request present
    input wire REQ_WRITE, // 1 write line, 0 read line
    input wire [`WBIM_ADDR_W-1:0] REQ_ADDR, // physical byte address
    input wire [`WBIM_DATA_W-1:0] REQ_WDATA, // line to write
    output wire REQ_READY, // request taken when high with REQ_VALID
    output wire RSP_VALID, // one-cycle answer to a local request
    output wire [`WBIM_DATA_W-1:0] RSP_RDATA, // corrected read line
    output wire RSP_CORRECTED, // a single-bit error was fixed
    output wire RSP_UNCORRECTABLE, // a multi-bit error was found
    output wire REQ_NOT_LOCAL, // one-cycle pulse: address maps to no local bank
    input wire [`WBIM_LINE_W-1:0] CFG_LOW_TOP, // first line above the low region
    input wire [`WBIM_WAYS_LOG2_W-1:0] CFG_LOW_WAYS, // log2 ways, low region
    input wire [`WBIM_WAYS_LOG2_W-1:0] CFG_HIGH_WAYS, // log2 ways, high region
    input wire [`WBIM_SLOT_W-1:0] CFG_LOW_SLOT0, // bank 0 slot in low group
    input wire [`WBIM_SLOT_W-1:0] CFG_LOW_SLOT1, // bank 1 slot in low group
    input wire [`WBIM_SLOT_W-1:0] CFG_HIGH_SLOT0, // bank 0 slot in high group
    input wire [`WBIM_SLOT_W-1:0] CFG_HIGH_SLOT1, // bank 1 slot in high group
    input wire [3:0] CFG_BANK_EN, // {high1, high0, low1, low0} membership
    output wire [`WBIM_BANKS-1:0] MEM_BANK_SEL, // bank select, active high
    output wire MEM_WRITE, // write strobe to the selected bank
    output wire [`WBIM_ROW_W-1:0] MEM_ROW, // row of in-bank line
    output wire [`WBIM_COL_W-1:0] MEM_COL, // column of in-bank line
    output wire [`WBIM_MEM_W-1:0] MEM_WDATA, // line plus check bits out
    input wire [`WBIM_MEM_W-1:0] MEM_RDATA // line plus check bits in
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ACCESS = 2'h1;
    localparam ST_RESP = 2'h2;
    localparam ST_RECOV = 2'h3;
    // settings word: top, two way counts, four slots, enables, two spare zero bits
    localparam CFG_W = `WBIM_LINE_W + 2 * `WBIM_WAYS_LOG2_W + 4 * `WBIM_SLOT_W + 4 + 2;
    // drive cycle, access time, then the input synchroniser stages
    localparam [`WBIM_CNT_W-1:0] ACC_END = ACC_CYC + `WBIM_SYNC_STAGES;
    localparam [`WBIM_CNT_W-1:0] REC_END = (REC_CYC > 0) ? REC_CYC - 1 : 0;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`WBIM_CNT_W-1:0] cnt_reg;
    reg [CFG_W-1:0] cfg_meta_reg;
    reg [CFG_W-1:0] cfg_sync_reg;
    reg [`WBIM_MEM_W-1:0] rd_meta_reg;
    reg [`WBIM_MEM_W-1:0] rd_sync_reg;
    reg [`WBIM_MEM_W-1:0] raw_reg;
    reg [`WBIM_DATA_W-1:0] wdata_reg;
    reg write_reg;
    reg [`WBIM_BANKS-1:0] bank_reg;
    reg [`WBIM_BANK_LINE_W-1:0] bline_reg;
    reg [`WBIM_BANKS-1:0] mem_sel_reg;
    reg mem_we_reg;
    reg [`WBIM_BANK_LINE_W-1:0] mem_line_reg;
    reg [`WBIM_MEM_W-1:0] mem_wdata_reg;
    reg rsp_valid_reg;
    reg [`WBIM_DATA_W-1:0] rsp_data_reg;
    reg rsp_ce_reg;
    reg rsp_ue_reg;
    reg not_local_reg;

    // unpack synchronised interleave settings
    wire [`WBIM_LINE_W-1:0] c_top = cfg_sync_reg[CFG_W-1 -: `WBIM_LINE_W];
    wire [`WBIM_WAYS_LOG2_W-1:0] c_w0 = cfg_sync_reg[27:25];
    wire [`WBIM_WAYS_LOG2_W-1:0] c_w1 = cfg_sync_reg[24:22];
    wire [`WBIM_SLOT_W-1:0] c_ls0 = cfg_sync_reg[21:18];
    wire [`WBIM_SLOT_W-1:0] c_ls1 = cfg_sync_reg[17:14];
    wire [`WBIM_SLOT_W-1:0] c_hs0 = cfg_sync_reg[13:10];
    wire [`WBIM_SLOT_W-1:0] c_hs1 = cfg_sync_reg[9:6];
    wire [3:0] c_en = cfg_sync_reg[5:2];

    // clamp ways to sixteen so a bad strap cannot alias the whole space
    wire [`WBIM_WAYS_LOG2_W-1:0] w_lo = (c_w0 > `WBIM_MAX_WAYS_LOG2) ?
        `WBIM_MAX_WAYS_LOG2 : c_w0; // R7
    wire [`WBIM_WAYS_LOG2_W-1:0] w_hi = (c_w1 > `WBIM_MAX_WAYS_LOG2) ?
        `WBIM_MAX_WAYS_LOG2 : c_w1; // R7

    // line index drops the 64-byte offset; slot comes from bits just above it
    wire [`WBIM_LINE_W-1:0] line = REQ_ADDR[`WBIM_ADDR_W-1:`WBIM_LINE_OFS]; // R4 R6
    wire in_low = line < c_top; // R8
    wire [`WBIM_LINE_W-1:0] rel = line - c_top; // R8
    wire [`WBIM_LINE_W-1:0] mask_lo = ~({`WBIM_LINE_W{1'b1}} << w_lo);
    wire [`WBIM_LINE_W-1:0] mask_hi = ~({`WBIM_LINE_W{1'b1}} << w_hi);
    wire [`WBIM_LINE_W-1:0] slot_lo_w = line & mask_lo; // R9
    wire [`WBIM_LINE_W-1:0] slot_hi_w = rel & mask_hi; // R9
    wire [`WBIM_SLOT_W-1:0] slot_lo = slot_lo_w[`WBIM_SLOT_W-1:0];
    wire [`WBIM_SLOT_W-1:0] slot_hi = slot_hi_w[`WBIM_SLOT_W-1:0];
    // high region lines stack on top of the banks' share of the low region
    wire [`WBIM_LINE_W-1:0] bl_lo = line >> w_lo; // R9
    wire [`WBIM_LINE_W-1:0] bl_hi = (c_top >> w_lo) + (rel >> w_hi); // R8
    wire [`WBIM_LINE_W-1:0] bl_sel = in_low ? bl_lo : bl_hi;

    // hit per local bank; bank 0 wins if straps wrongly claim one slot twice
    wire hit0 = in_low ? (c_en[0] && (slot_lo == c_ls0)) : (c_en[2] && (slot_hi == c_hs0));
    wire hit1 = in_low ? (c_en[1] && (slot_lo == c_ls1)) : (c_en[3] && (slot_hi == c_hs1));
    wire [`WBIM_BANKS-1:0] hit = {hit1 & ~hit0, hit0}; // R2 R6

    wire take = REQ_VALID && (state_reg == ST_IDLE);
    assign REQ_READY = (state_reg == ST_IDLE);

    // eight word lanes of check logic across the wide line
    wire [`WBIM_CHECK_W-1:0] enc_chk;
    wire [`WBIM_DATA_W-1:0] fix_data;
    wire [`WBIM_WORDS-1:0] lane_ce;
    wire [`WBIM_WORDS-1:0] lane_ue;
    genvar g;
    generate
        for (g = 0; g < `WBIM_WORDS; g = g + 1) begin : lane
            wire [`WBIM_WORD_W-1:0] din = write_reg ?
                wdata_reg[g*`WBIM_WORD_W +: `WBIM_WORD_W] :
                raw_reg[g*`WBIM_WORD_W +: `WBIM_WORD_W];
            wbim_ecc u_ecc (
                .data_in(din),
                .chk_in(raw_reg[`WBIM_DATA_W + g*`WBIM_WORD_CHK_W +: `WBIM_WORD_CHK_W]),
                .chk_out(enc_chk[g*`WBIM_WORD_CHK_W +: `WBIM_WORD_CHK_W]),
                .data_fix(fix_data[g*`WBIM_WORD_W +: `WBIM_WORD_W]),
                .err_single(lane_ce[g]),
                .err_double(lane_ue[g])
            );
        end
    endgenerate

    // next state of the single-outstanding access sequencer
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && (hit != 2'h0))
                    state_next = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (cnt_reg == ACC_END)
                    state_next = ST_RESP;
            end
            ST_RESP: begin
                state_next = ST_RECOV;
            end
            ST_RECOV: begin
                if (cnt_reg >= REC_END)
                    state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // settings and read data are pins, so both pass two flops first
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_meta_reg <= {CFG_W{1'b0}};
            cfg_sync_reg <= {CFG_W{1'b0}};
            rd_meta_reg <= {`WBIM_MEM_W{1'b0}};
            rd_sync_reg <= {`WBIM_MEM_W{1'b0}};
        end else begin
            cfg_meta_reg <= {CFG_LOW_TOP, CFG_LOW_WAYS, CFG_HIGH_WAYS, CFG_LOW_SLOT0,
                CFG_LOW_SLOT1, CFG_HIGH_SLOT0, CFG_HIGH_SLOT1, CFG_BANK_EN, 2'h0};
            cfg_sync_reg <= cfg_meta_reg;
            rd_meta_reg <= MEM_RDATA;
            rd_sync_reg <= rd_meta_reg;
        end
    end

    // sequencer, bank drive and answer registers
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            cnt_reg <= {`WBIM_CNT_W{1'b0}};
            raw_reg <= {`WBIM_MEM_W{1'b0}};
            wdata_reg <= {`WBIM_DATA_W{1'b0}};
            write_reg <= 1'b0;
            bank_reg <= 2'h0;
            bline_reg <= {`WBIM_BANK_LINE_W{1'b0}};
            mem_sel_reg <= 2'h0;
            mem_we_reg <= 1'b0;
            mem_line_reg <= {`WBIM_BANK_LINE_W{1'b0}};
            mem_wdata_reg <= {`WBIM_MEM_W{1'b0}};
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= {`WBIM_DATA_W{1'b0}};
            rsp_ce_reg <= 1'b0;
            rsp_ue_reg <= 1'b0;
            not_local_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rsp_valid_reg <= 1'b0;
            not_local_reg <= 1'b0;
            if (state_next != state_reg)
                cnt_reg <= {`WBIM_CNT_W{1'b0}};
            else
                cnt_reg <= cnt_reg + 8'h01;
            case (state_reg)
                ST_IDLE: begin
                    if (take) begin
                        write_reg <= REQ_WRITE;
                        wdata_reg <= REQ_WDATA;
                        bank_reg <= hit;
                        bline_reg <= bl_sel[`WBIM_BANK_LINE_W-1:0]; // R3
                        not_local_reg <= (hit == 2'h0);
                    end
                end
                ST_ACCESS: begin
                    // whole line plus check bits to one bank in one transfer
                    mem_sel_reg <= bank_reg; // R1 R2
                    mem_we_reg <= write_reg;
                    mem_line_reg <= bline_reg; // R3
                    mem_wdata_reg <= {enc_chk, wdata_reg}; // R1
                    if (cnt_reg == ACC_END)
                        raw_reg <= rd_sync_reg; // R1
                end
                ST_RESP: begin
                    mem_sel_reg <= 2'h0;
                    mem_we_reg <= 1'b0;
                    rsp_valid_reg <= 1'b1;
                    rsp_data_reg <= write_reg ? {`WBIM_DATA_W{1'b0}} : fix_data; // R5
                    rsp_ce_reg <= (!write_reg) && (lane_ce != 8'h00); // R5
                    rsp_ue_reg <= (!write_reg) && (lane_ue != 8'h00);
                end
                default: begin
                    mem_sel_reg <= 2'h0;
                    mem_we_reg <= 1'b0;
                end
            endcase
        end
    end

    assign RSP_VALID = rsp_valid_reg;
    assign RSP_RDATA = rsp_data_reg;
    assign RSP_CORRECTED = rsp_ce_reg;
    assign RSP_UNCORRECTABLE = rsp_ue_reg;
    assign REQ_NOT_LOCAL = not_local_reg;
    assign MEM_BANK_SEL = mem_sel_reg;
    assign MEM_WRITE = mem_we_reg;
    assign MEM_ROW = mem_line_reg[`WBIM_BANK_LINE_W-1:`WBIM_COL_W]; // R3
    assign MEM_COL = mem_line_reg[`WBIM_COL_W-1:0]; // R3
    assign MEM_WDATA = mem_wdata_reg;
endmodule

// ==== sim/wbim_ctrl_checker.sv ====
/*
 checker for the memory controller: handshake, bank select and answer timing.
 assumes a single clock CLK with asynchronous reset RST, bound to wbim_ctrl.
*/
`timescale 1ns/10ps
`include "wbim_regs.vh"
module wbim_ctrl_checker #(
    parameter ACC_CYC = 1
) (
    input wire CLK, // system clock
    input wire RST, // async reset
    input wire REQ_VALID, // request present
    input wire REQ_WRITE, // write request
    input wire REQ_READY, // request accepted
    input wire RSP_VALID, // answer pulse
    input wire [`WBIM_DATA_W-1:0] RSP_RDATA, // read line
    input wire RSP_CORRECTED, // single error fixed
    input wire RSP_UNCORRECTABLE, // multi error seen
    input wire REQ_NOT_LOCAL, // no local bank
    input wire [`WBIM_BANKS-1:0] MEM_BANK_SEL, // bank select
    input wire MEM_WRITE // bank write strobe
);
    localparam int RSP_MIN = ACC_CYC + 2;
    localparam int RSP_MAX = ACC_CYC + 5;
    logic wr_reg;

    // remember the kind of the request in flight, answers carry no kind
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_reg <= 1'b0;
        end else if (REQ_VALID && REQ_READY) begin
            wr_reg <= REQ_WRITE;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_take;
        REQ_VALID && REQ_READY;
    endsequence
    sequence s_local_take;
        s_take ##1 !REQ_NOT_LOCAL;
    endsequence

    a_rsp_single_pulse: assert property (RSP_VALID |=> !RSP_VALID)
        else $error("answer pulse longer than one cycle");
    a_take_answer: assert property (s_local_take |-> ##[RSP_MIN:RSP_MAX] RSP_VALID)
        else $error("local request not answered in time");
    a_write_zero_line: assert property (RSP_VALID && wr_reg |-> RSP_RDATA == '0)
        else $error("write answer carries data");
    a_bank_onehot: assert property ($onehot0(MEM_BANK_SEL))
        else $error("more than one bank selected");
    a_idle_no_select: assert property (REQ_READY |-> MEM_BANK_SEL == '0)
        else $error("bank selected while idle");
    a_write_has_bank: assert property (MEM_WRITE |-> MEM_BANK_SEL != '0)
        else $error("write strobe without bank");
    // recovery overlaps the answer cycle; with the default single recovery cycle
    // the controller takes requests again right after the answer
    a_busy_until_rec: assert property (RSP_VALID |-> !REQ_READY ##1 REQ_READY)
        else $error("ready before recovery");
    a_remote_no_access: assert property (REQ_NOT_LOCAL |-> MEM_BANK_SEL == '0 && !RSP_VALID)
        else $error("remote line touched a bank");
    a_flags_exclusive: assert property (RSP_VALID |-> !(RSP_CORRECTED && RSP_UNCORRECTABLE))
        else $error("both error flags set");
endmodule

bind wbim_ctrl wbim_ctrl_checker #(.ACC_CYC(ACC_CYC)) u_wbim_ctrl_checker (
    .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .RSP_CORRECTED(RSP_CORRECTED), .RSP_UNCORRECTABLE(RSP_UNCORRECTABLE),
    .REQ_NOT_LOCAL(REQ_NOT_LOCAL), .MEM_BANK_SEL(MEM_BANK_SEL), .MEM_WRITE(MEM_WRITE));

// ==== sim/wbim_bank_model.sv ====
/*
 behavioural model of the two module banks: stores whole lines with check bits.
 assumes only row bit 8 and column bits 1:0 differ among the lines used.
*/
`timescale 1ns/10ps
`include "wbim_regs.vh"
module wbim_bank_model (
    input wire CLK, // system clock
    input wire [`WBIM_BANKS-1:0] MEM_BANK_SEL, // bank select
    input wire MEM_WRITE, // write strobe
    input wire [`WBIM_ROW_W-1:0] MEM_ROW, // row
    input wire [`WBIM_COL_W-1:0] MEM_COL, // column
    input wire [`WBIM_MEM_W-1:0] MEM_WDATA, // line plus check in
    input wire [`WBIM_MEM_W-1:0] flip_mask, // bits to corrupt on read
    output logic [`WBIM_MEM_W-1:0] MEM_RDATA // line plus check out
);
    logic [`WBIM_MEM_W-1:0] mem [0:15];
    logic [`WBIM_MEM_W-1:0] last = '0;
    wire [3:0] key = {MEM_BANK_SEL[1], MEM_ROW[8], MEM_COL[1:0]};
    wire rd = (MEM_BANK_SEL != '0) && !MEM_WRITE;

    // a whole 576-bit word lands in one cycle, eight modules side by side
    always @(posedge CLK) begin
        if (MEM_BANK_SEL != '0 && MEM_WRITE) begin
            mem[key] <= MEM_WDATA;
        end
        if (rd) begin
            last <= MEM_RDATA;
        end
    end

    // deselected banks show the inverse of the last word, never a stale copy
    always @* begin
        MEM_RDATA = rd ? (mem[key] ^ flip_mask) : ~last;
    end
endmodule

// ==== sim/testbench.sv ====
/*
 self-checking bench for wbim_ctrl with the bank model on its memory side.
 assumes default timing parameters and interleave pins changed only when idle.
*/
`timescale 1ns/10ps
`include "wbim_regs.vh"
module testbench;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [`WBIM_ADDR_W-1:0] req_addr = '0;
    logic [`WBIM_DATA_W-1:0] req_wdata = '0;
    logic [`WBIM_LINE_W-1:0] low_top = 35'h1000000; // four 256 MB pieces
    logic [2:0] low_ways = 3'h2;
    logic [2:0] high_ways = 3'h1;
    logic [3:0] ls0 = 4'h0;
    logic [3:0] ls1 = 4'h1;
    logic [3:0] bank_en = 4'hf;
    logic [`WBIM_MEM_W-1:0] flip = '0;
    wire ready, rsp_valid, rsp_corr, rsp_unc, not_local, mem_write;
    wire [`WBIM_DATA_W-1:0] rsp_rdata;
    wire [1:0] bank_sel;
    wire [13:0] mem_row, mem_col;
    wire [`WBIM_MEM_W-1:0] mem_wdata, mem_rdata;
    int error_cnt = 0;
    int compares = 0;
    logic [1:0] got_sel;
    logic [13:0] got_row, got_col;
    logic [511:0] got_data;
    logic got_corr, got_unc, got_nl;

    wbim_ctrl u_wbim_ctrl (.CLK(CLK), .RST(RST), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(ready), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rsp_rdata), .RSP_CORRECTED(rsp_corr), .RSP_UNCORRECTABLE(rsp_unc),
        .REQ_NOT_LOCAL(not_local), .CFG_LOW_TOP(low_top), .CFG_LOW_WAYS(low_ways),
        .CFG_HIGH_WAYS(high_ways), .CFG_LOW_SLOT0(ls0), .CFG_LOW_SLOT1(ls1),
        .CFG_HIGH_SLOT0(4'h0), .CFG_HIGH_SLOT1(4'h1), .CFG_BANK_EN(bank_en),
        .MEM_BANK_SEL(bank_sel), .MEM_WRITE(mem_write), .MEM_ROW(mem_row), .MEM_COL(mem_col),
        .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));
    wbim_bank_model u_wbim_bank_model (.CLK(CLK), .MEM_BANK_SEL(bank_sel),
        .MEM_WRITE(mem_write), .MEM_ROW(mem_row), .MEM_COL(mem_col), .MEM_WDATA(mem_wdata),
        .flip_mask(flip), .MEM_RDATA(mem_rdata));

    initial begin
        forever #50 CLK = ~CLK;
    end

    task automatic end_of_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [511:0] exp, input logic [511:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [511:0] pat(input int v);
        return {16{32'(v) ^ 32'h5a5aa5a5}};
    endfunction

    // one line request; offset bits 5:0 are set to 6'h2a to show they are ignored
    task automatic do_req(input logic wr, input logic [34:0] line);
        int n;
        @(negedge CLK);
        for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge CLK);
        if (n == 20) begin
            error_cnt++;
            end_of_test();
        end
        req_valid = 1'b1;
        req_write = wr;
        req_addr = {line, 6'h2a};
        req_wdata = pat(int'(line));
        @(negedge CLK);
        req_valid = 1'b0;
        got_sel = '0;
        for (n = 0; n < 20 && rsp_valid !== 1'b1 && not_local !== 1'b1; n++) begin
            if (bank_sel != '0) {got_sel, got_row, got_col} = {bank_sel, mem_row, mem_col};
            @(negedge CLK);
        end
        if (n == 20) begin
            error_cnt++;
            end_of_test();
        end
        {got_nl, got_data, got_corr, got_unc} = {not_local, rsp_rdata, rsp_corr, rsp_unc};
    endtask

    // low region, four ways: slots 2 and 3 belong to other boards
    task automatic t_low_map;
        for (int i = 0; i < 8; i++) begin
            do_req(1'b1, 35'(i));
            chk("not_local", 512'((i % 4) > 1), 512'(got_nl));
            if (!got_nl) begin
                chk("bank", 512'(2'b1 << (i % 4)), 512'(got_sel));
                chk("col", 512'(i / 4), 512'(got_col));
                chk("wr_data", '0, got_data);
            end
        end
    endtask

    // rest of the large banks, two ways, above the low region
    task automatic t_high_map;
        for (int k = 0; k < 4; k++) begin
            do_req(1'b1, low_top + 35'(k));
            chk("bank", 512'(2'b1 << (k % 2)), 512'(got_sel));
            chk("row", 512'(14'h100), 512'(got_row));
            chk("col", 512'(k / 2), 512'(got_col));
        end
    endtask

    // read back clean, then single errors in data and check bits, then a double
    task automatic t_read_ecc;
        logic [575:0] masks [0:3];
        masks = '{576'h0, 576'h1 << 77, 576'h1 << 515, 576'h3 << 128};
        for (int m = 0; m < 4; m++) begin
            flip = masks[m];
            do_req(1'b0, 35'h5);
            if (m < 3) chk("rd_data", pat(5), got_data);
            chk("corrected", 512'(m == 1 || m == 2), 512'(got_corr));
            chk("uncorrectable", 512'(m == 3), 512'(got_unc));
        end
        flip = '0;
        do_req(1'b0, low_top + 35'h3);
        chk("rd_data", pat(int'(low_top) + 3), got_data);
    endtask

    // sixteen-way group: local banks in slots 15 and 3
    task automatic t_wide;
        low_ways = 3'h4;
        ls0 = 4'hf;
        ls1 = 4'h3;
        repeat (3) @(negedge CLK);
        do_req(1'b1, 35'd15);
        chk("bank", 512'(2'b01), 512'(got_sel));
        do_req(1'b1, 35'd19);
        chk("bank", 512'(2'b10), 512'(got_sel));
        chk("col", 512'(1), 512'(got_col));
        do_req(1'b1, 35'd16);
        chk("not_local", 512'(1), 512'(got_nl));
    endtask

    initial begin
        repeat (20) @(negedge CLK);
        RST = 1'b0;
        repeat (3) @(negedge CLK);
        t_low_map();
        t_high_map();
        t_read_ecc();
        t_wide();
        end_of_test();
    end
endmodule
